// ---- logic/dswd_kick_sync.sv ----
// turns the strobe level into a one-cycle kick pulse on its falling edge
module dswd_kick_sync
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic kick_in_n,
    output logic      kick_pulse
);
    typedef struct packed {
        logic prev;
    } dswd_ks_t;

    dswd_ks_t st_r;
    dswd_ks_t st_nxt;

    // remember last level; input already synchronous
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.prev = kick_in_n;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '{prev: 1'b1};
        else
            st_r <= st_nxt;
    end

    assign kick_pulse = st_r.prev && !kick_in_n;
endmodule : dswd_kick_sync

// ---- logic/dswd_pkg.sv ----
package dswd_pkg;
    // stage action encodings
    typedef enum logic [2:0] {
        DSWD_ACT_NONE,
        DSWD_ACT_RESET,
        DSWD_ACT_DELAY,
        DSWD_ACT_ALERT,
        DSWD_ACT_RESET_ALERT,
        DSWD_ACT_DELAY_ALERT
    } dswd_action_t;

    localparam int unsigned DSWD_CNT_W   = 32;
    localparam int unsigned DSWD_PULSE_W = 8;
    // reset values
    localparam logic [31:0] DSWD_CNT_RST   = 32'h0000_0000;
    // module reset pulse, cycles
    localparam logic [7:0]  DSWD_RST_CYCLES = 8'h10;
endpackage : dswd_pkg

// ---- logic/dswd_watchdog.sv ----
// Behaviour
// - Two stages run one after the other, stage two after stage one times out or when stage one is skipped.
// - A stage set to no action is skipped and has no effect.
// - A stage set to reset pulses the module reset output on expiry.
// - The delay setting is accepted in stage one only; in stage two it acts as no action.
// - Alert-only asserts the alert output and does not reset.
// - Reset plus alert, and delay plus alert in stage one, are supported.
// - Each falling edge of the active-low strobe restarts the enabled timer.
// - The alert output rises only when the expiring stage's action includes it.
// - Strobe and alert pass through the controller pin pair for the watchdog.
module dswd_watchdog
#(
    parameter int unsigned CNT_W = dswd_pkg::DSWD_CNT_W
)
(
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 enable,
    input  wire logic [2:0]           stage1_action,
    input  wire logic [2:0]           stage2_action,
    input  wire logic [CNT_W-1:0]     stage1_count,
    input  wire logic [CNT_W-1:0]     stage2_count,
    input  wire logic [CNT_W-1:0]     delay_count,
    input  wire logic                 controller_pin_kick,
    output logic                      controller_pin_alert,
    output logic                      timeout_alert_out,
    output logic                      module_reset_out,
    output logic [1:0]                stage_out
);
    if (CNT_W < 2 || CNT_W > 32)
    begin : g_chk
        $error("CNT_W out of range");
    end

    typedef enum logic [1:0] {
        DSWD_IDLE,
        DSWD_STAGE1,
        DSWD_STAGE2,
        DSWD_DONE
    } dswd_state_t;

    typedef struct packed {
        dswd_state_t      state;
        logic [CNT_W-1:0] cnt;
        logic             delayed;
        logic             alert;
        logic [7:0]       rst_cnt;
    } dswd_st_t;

    dswd_st_t st_r;
    dswd_st_t st_nxt;
    logic     kick;

    // strobe arrives on the controller kick pin
    dswd_kick_sync u_kick
    (
        .clk        (clk),
        .reset_n    (reset_n),
        .kick_in_n  (controller_pin_kick),
        .kick_pulse (kick)
    );

    // decode helpers; alert and reset used for both stages, delay for stage one only
    function automatic logic act_alert(input logic [2:0] a);
        act_alert = (a == 3'(dswd_pkg::DSWD_ACT_ALERT))
                 || (a == 3'(dswd_pkg::DSWD_ACT_RESET_ALERT))
                 || (a == 3'(dswd_pkg::DSWD_ACT_DELAY_ALERT));
    endfunction : act_alert

    function automatic logic act_reset(input logic [2:0] a);
        act_reset = (a == 3'(dswd_pkg::DSWD_ACT_RESET))
                 || (a == 3'(dswd_pkg::DSWD_ACT_RESET_ALERT));
    endfunction : act_reset

    function automatic logic act_delay(input logic [2:0] a);
        act_delay = (a == 3'(dswd_pkg::DSWD_ACT_DELAY))
                 || (a == 3'(dswd_pkg::DSWD_ACT_DELAY_ALERT));
    endfunction : act_delay

    // stage counts as live if it has any effect; delay is ignored in stage two
    function automatic logic live2(input logic [2:0] a);
        live2 = act_alert(a) || act_reset(a);
    endfunction : live2

    function automatic logic live1(input logic [2:0] a);
        live1 = live2(a) || act_delay(a);
    endfunction : live1

    // next-state logic
    always_comb
    begin
        st_nxt = st_r;
        if (st_r.rst_cnt != 8'h00)
            st_nxt.rst_cnt = st_r.rst_cnt - 8'h01;
        if (!enable)
        begin
            st_nxt.state   = DSWD_IDLE;
            st_nxt.cnt     = '0;
            st_nxt.delayed = 1'b0;
            st_nxt.alert   = 1'b0;
        end
        else
        begin
            unique case (st_r.state)
                DSWD_IDLE:
                begin
                    // first window may be stretched by the delay setting
                    st_nxt.delayed = act_delay(stage1_action);
                    st_nxt.cnt     = act_delay(stage1_action) ? delay_count : stage1_count;
                    st_nxt.state   = live1(stage1_action) ? DSWD_STAGE1 :
                                     live2(stage2_action) ? DSWD_STAGE2 : DSWD_DONE;
                    if (!live1(stage1_action))
                        st_nxt.cnt = stage2_count;
                end
                DSWD_STAGE1:
                begin
                    if (kick)
                    begin
                        // after the first strobe the delay no longer applies
                        st_nxt.cnt     = stage1_count;
                        st_nxt.delayed = 1'b0;
                    end
                    else if (st_r.cnt == '0)
                    begin
                        if (act_alert(stage1_action))
                            st_nxt.alert = 1'b1;
                        if (act_reset(stage1_action))
                            st_nxt.rst_cnt = dswd_pkg::DSWD_RST_CYCLES;
                        st_nxt.cnt   = stage2_count;
                        st_nxt.state = live2(stage2_action) ? DSWD_STAGE2 : DSWD_DONE;
                    end
                    else
                        st_nxt.cnt = st_r.cnt - CNT_W'(1);
                end
                DSWD_STAGE2:
                begin
                    if (kick)
                    begin
                        st_nxt.cnt   = stage1_count;
                        st_nxt.state = live1(stage1_action) ? DSWD_STAGE1 : DSWD_STAGE2;
                        if (!live1(stage1_action))
                            st_nxt.cnt = stage2_count;
                    end
                    else if (st_r.cnt == '0)
                    begin
                        if (act_alert(stage2_action))
                            st_nxt.alert = 1'b1;
                        if (act_reset(stage2_action))
                            st_nxt.rst_cnt = dswd_pkg::DSWD_RST_CYCLES;
                        st_nxt.state = DSWD_DONE;
                    end
                    else
                        st_nxt.cnt = st_r.cnt - CNT_W'(1);
                end
                DSWD_DONE:
                begin
                    // a strobe rearms; alert stays until rearmed or disabled
                    if (kick)
                    begin
                        st_nxt.state = DSWD_IDLE;
                        st_nxt.alert = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '{state: DSWD_IDLE, cnt: CNT_W'(dswd_pkg::DSWD_CNT_RST), delayed: 1'b0,
                      alert: 1'b0, rst_cnt: 8'h00};
        else
            st_r <= st_nxt;
    end

    assign timeout_alert_out    = st_r.alert;
    assign controller_pin_alert = st_r.alert;
    assign module_reset_out     = (st_r.rst_cnt != 8'h00);
    assign stage_out            = st_r.state;

    // checks
    property p_disabled_quiet;
        @(posedge clk) disable iff (!reset_n)
        !enable |=> (stage_out == 2'd0) && !timeout_alert_out;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled watchdog active");

    property p_alert_cause;
        @(posedge clk) disable iff (!reset_n)
        $rose(timeout_alert_out) |-> $past(st_r.cnt == '0)
            && ($past(st_r.state) == DSWD_STAGE1 ? act_alert($past(stage1_action))
                                                 : act_alert($past(stage2_action)));
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert without cause");

    property p_reset_len;
        @(posedge clk) disable iff (!reset_n)
        $rose(module_reset_out) |-> module_reset_out [*8];
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset pulse short");

    property p_stage_order;
        @(posedge clk) disable iff (!reset_n)
        (st_r.state == DSWD_STAGE2) && $past(st_r.state) == DSWD_IDLE |-> !live1($past(stage1_action));
    endproperty
    a_stage_order: assert property (p_stage_order) else $error("stage one bypassed");

    property p_kick_restart;
        @(posedge clk) disable iff (!reset_n)
        enable && kick && st_r.state == DSWD_STAGE1 |=> st_r.cnt == $past(stage1_count)
            || !enable;
    endproperty
    a_kick_restart: assert property (p_kick_restart) else $error("strobe did not restart");

    property p_stage2_back;
        @(posedge clk) disable iff (!reset_n)
        enable && kick && st_r.state == DSWD_STAGE2 && live1(stage1_action)
            |=> st_r.state == DSWD_STAGE1 || !enable;
    endproperty
    a_stage2_back: assert property (p_stage2_back) else $error("strobe kept stage two");

    property p_alert_only_no_reset;
        @(posedge clk) disable iff (!reset_n)
        enable && st_r.state == DSWD_STAGE1 && st_r.cnt == '0 && !kick
            && stage1_action == 3'(dswd_pkg::DSWD_ACT_ALERT) && !module_reset_out
            |=> !module_reset_out;
    endproperty
    a_alert_only_no_reset: assert property (p_alert_only_no_reset) else $error("alert reset");

    property p_skip_none;
        @(posedge clk) disable iff (!reset_n)
        enable && st_r.state == DSWD_IDLE && !live1(stage1_action) |=> st_r.state != DSWD_STAGE1;
    endproperty
    a_skip_none: assert property (p_skip_none) else $error("no-action stage entered");

    property p_delay2_ignored;
        @(posedge clk) disable iff (!reset_n)
        st_r.state == DSWD_STAGE2 |-> live2(stage2_action) || $changed(stage2_action)
            || $past(kick);
    endproperty
    a_delay2_ignored: assert property (p_delay2_ignored) else $error("delay in stage two");

    c_alert: cover property (@(posedge clk) disable iff (!reset_n) $rose(timeout_alert_out));
    c_reset: cover property (@(posedge clk) disable iff (!reset_n) $rose(module_reset_out));
    c_stage2: cover property (@(posedge clk) disable iff (!reset_n)
        st_r.state == DSWD_STAGE2 && kick);
endmodule : dswd_watchdog

// ---- testbench/dswd_carrier_model.sv ----
// carrier side: strobes the watchdog on request, watches the alert pin
module dswd_carrier_model
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic kick_req,
    input  wire logic alert_in,
    output logic      strobe_n,
    output logic      alert_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] low_r;
    // two low cycles per request, so the falling edge is never missed
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            low_r <= 2'h0;
        else if (kick_req)
            low_r <= 2'h2;
        else if (low_r != 2'h0)
            low_r <= low_r - 2'h1;
    end
    assign strobe_n = (low_r == 2'h0); // idles high
    // sampled copy of the alert pin
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            alert_seen <= 1'b0;
        else
            alert_seen <= alert_in;
    end
endmodule : dswd_carrier_model

// ---- testbench/dswd_watchdog_bench.sv ----
module dswd_watchdog_bench;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
    logic        clk, reset_n, enable, kick_req, strobe_n, seen, pin, alert, mrst;
    logic [2:0]  a1, a2;
    logic [31:0] c1, c2, cd;
    logic [1:0]  stage;
    int          n_fail, comparisons, n;
    dswd_watchdog dswd_watchdog_inst (.clk(clk), .reset_n(reset_n), .enable(enable),
        .stage1_action(a1), .stage2_action(a2), .stage1_count(c1), .stage2_count(c2),
        .delay_count(cd), .controller_pin_kick(strobe_n), .controller_pin_alert(pin),
        .timeout_alert_out(alert), .module_reset_out(mrst), .stage_out(stage));
    dswd_carrier_model dswd_carrier_model_inst (.clk(clk), .reset_n(reset_n),
        .kick_req(kick_req), .alert_in(pin), .strobe_n(strobe_n), .alert_seen(seen));
    // 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_sim();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // inputs move 1 ns after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic arm(input logic [2:0] x1, x2, input logic [31:0] y1, y2, yd);
        enable = 1'b0;
        a1 = x1;
        a2 = x2;
        c1 = y1;
        c2 = y2;
        cd = yd;
        step(2);
        enable = 1'b1;
    endtask : arm
    // bounded wait; running out counts as a mismatch
    task automatic wait_stage(input logic [1:0] s);
        int i;
        i = 0;
        while (stage !== s && i < 300)
        begin
            step(1);
            i++;
        end
        if (i == 300)
        begin
            n_fail++;
            end_sim();
        end
    endtask : wait_stage
    // cycles spent in stage s from now on
    task automatic span(input logic [1:0] s, output int k);
        k = 0;
        while (stage === s && k < 300)
        begin
            step(1);
            k++;
        end
    endtask : span
    task automatic kick();
        kick_req = 1'b1;
        step(1);
        kick_req = 1'b0;
    endtask : kick
    task automatic s_chain();
        arm(dswd_pkg::DSWD_ACT_ALERT, dswd_pkg::DSWD_ACT_RESET, 32'h0000_0004, 32'h0000_0006, 0);
        wait_stage(2'h1);
        span(2'h1, n);
        `CHK(n, 5)
        `CHK(stage, 2'h2)
        `CHK(alert, 1'b1)
        `CHK(mrst, 1'b0)
        `CHK(pin, alert)
        span(2'h2, n);
        `CHK(n, 7)
        `CHK(mrst, 1'b1)
        for (n = 0; mrst === 1'b1 && n < 50; n++)
            step(1);
        `CHK(n, int'(dswd_pkg::DSWD_RST_CYCLES))
        `CHK(seen, 1'b1)
    endtask : s_chain
    task automatic s_skip();
        arm(dswd_pkg::DSWD_ACT_NONE, dswd_pkg::DSWD_ACT_RESET_ALERT, 4, 32'h0000_0003, 0);
        for (n = 0; stage === 2'h0 && n < 20; n++)
            step(1);
        `CHK(stage, 2'h2)
        `CHK(alert, 1'b0)
        span(2'h2, n);
        `CHK(n, 4)
        `CHK(alert, 1'b1)
        `CHK(mrst, 1'b1)
        // let the reset pulse run out, or it leaks into the next scenario
        for (n = 0; mrst === 1'b1 && n < 50; n++)
            step(1);
        `CHK(n, int'(dswd_pkg::DSWD_RST_CYCLES))
    endtask : s_skip
    task automatic s_delay();
        arm(dswd_pkg::DSWD_ACT_DELAY_ALERT, dswd_pkg::DSWD_ACT_DELAY, 3, 3, 32'h0000_0008);
        wait_stage(2'h1);
        span(2'h1, n);
        `CHK(n, 9)
        `CHK(alert, 1'b1)
        wait_stage(2'h3);
        `CHK(mrst, 1'b0)
    endtask : s_delay
    // delay alone: first strobe swaps the long window for the normal one
    task automatic s_delay_kick();
        arm(dswd_pkg::DSWD_ACT_DELAY, dswd_pkg::DSWD_ACT_ALERT, 3, 2, 32'h0000_000a);
        wait_stage(2'h1);
        kick();
        span(2'h1, n);
        `CHK(n, 5)
        `CHK(stage, 2'h2)
        `CHK(alert, 1'b0)
        `CHK(mrst, 1'b0)
        span(2'h2, n);
        `CHK(n, 3)
        `CHK(alert, 1'b1)
        `CHK(mrst, 1'b0)
    endtask : s_delay_kick
    task automatic s_kick();
        arm(dswd_pkg::DSWD_ACT_ALERT, dswd_pkg::DSWD_ACT_ALERT, 5, 32'h0000_0014, 0);
        wait_stage(2'h1);
        repeat (8)
        begin
            kick();
            step(3);
        end
        `CHK(stage, 2'h1)
        `CHK(alert, 1'b0)
        wait_stage(2'h2);
        `CHK(alert, 1'b1)
        kick();
        step(4);
        `CHK(stage, 2'h1)
    endtask : s_kick
    task automatic s_off();
        enable = 1'b0;
        step(3);
        `CHK(stage, 2'h0)
        `CHK(alert, 1'b0)
        step(20);
        `CHK(stage, 2'h0)
        // a strobe while disabled must not start anything
        kick();
        step(3);
        `CHK(stage, 2'h0)
        `CHK(alert, 1'b0)
    endtask : s_off
    // main sequence: reset for five cycles, then each scenario
    initial
    begin
        {reset_n, enable, kick_req, a1, a2, c1, c2, cd} = '0;
        n_fail = 0;
        comparisons = 0;
        step(5);
        reset_n = 1'b1;
        `CHK({alert, pin, mrst, stage}, 5'h00)
        s_chain();
        s_skip();
        s_delay();
        s_delay_kick();
        s_kick();
        s_off();
        end_sim();
    end
endmodule : dswd_watchdog_bench
